// >>> adcsc_defines.svh
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH

// Byte addresses on the CPU port (8-bit writes, 8- or 16-bit reads)
`define ADCSC_ADDR_RES_HI   4'h0
`define ADCSC_ADDR_RES_LAST 4'h7
`define ADCSC_ADDR_CSR      4'h8
`define ADCSC_ADDR_TRG      4'h9

// Control/status bit positions
`define ADCSC_CSR_FLAG  7
`define ADCSC_CSR_IE    6
`define ADCSC_CSR_START 5
`define ADCSC_CSR_SCAN  4
`define ADCSC_CSR_CKS   3
`define ADCSC_TRG_EN    7

`define ADCSC_CSR_RESET   8'h00
`define ADCSC_TRG_RSVD    6'h3f
`define ADCSC_RES_RESET   10'h000
`define ADCSC_RES_PAD     6'h00

// Conversion time in states (one state is one clock cycle)
`define ADCSC_CONV_STATES_SLOW 8'h86
`define ADCSC_CONV_STATES_FAST 8'h46

`endif

// >>> adcsc_pkg.sv
package adcsc_pkg;
  typedef enum logic [0:0] {
    ADCSC_IDLE = 1'b0,
    ADCSC_BUSY = 1'b1
  } adcsc_state_t;
endpackage

// >>> adcsc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defines.svh"
module adcsc_core (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Handshake
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       fast,
  input  wire logic [9:0] sample,
  output logic            done,
  output logic [9:0]      result
);
  logic [7:0] cnt_q;
  logic       busy_q;
  logic [9:0] hold_q;

  // Sample held from start, delivered after the selected state count
  always_ff @(posedge clk) begin
    if (!resetn || abort) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
      hold_q <= `ADCSC_RES_RESET;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q  <= fast ? `ADCSC_CONV_STATES_FAST - 8'h01
                     : `ADCSC_CONV_STATES_SLOW - 8'h01;
      hold_q <= sample;
    end else if (busy_q) begin
      if (cnt_q == 8'h00) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || abort) begin
      done   <= 1'b0;
      result <= `ADCSC_RES_RESET;
    end else begin
      done   <= busy_q && (cnt_q == 8'h00) && !start;
      result <= hold_q;
    end
  end
endmodule
`default_nettype wire

// >>> adcsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defines.svh"
module adcsc_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       standby,
  // CPU port
  input  wire logic [3:0] cpu_addr,
  input  wire logic       cpu_rd,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_word,
  input  wire logic [7:0] cpu_wdata,
  output logic [15:0]     cpu_rdata,
  // Converted input levels
  input  wire logic [9:0] analog_input_0,
  input  wire logic [9:0] analog_input_1,
  input  wire logic [9:0] analog_input_2,
  input  wire logic [9:0] analog_input_3,
  input  wire logic [9:0] analog_input_4,
  input  wire logic [9:0] analog_input_5,
  input  wire logic [9:0] analog_input_6,
  input  wire logic [9:0] analog_input_7,
  // Trigger and interrupt
  input  wire logic       ext_trigger_pin,
  output logic            conversion_end_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  adcsc_pkg::adcsc_state_t state_q;

  logic       conversion_end_flag_q;
  logic       end_interrupt_enable_q;
  logic       conversion_start_bit_q;
  logic       scan_mode_q;
  logic       conv_time_select_q;
  logic [2:0] channel_field_q;
  logic       ext_trigger_enable_q;
  logic       trg_rsvd0_q;
  logic       trg_pin_q;
  logic       flag_read_one_q;
  logic [1:0] scan_idx_q;
  logic [7:0] temp_q;
  logic [9:0] result_q [4];

  logic       clr_n;
  logic       csr_wr;
  logic       trg_wr;
  logic       trig_fall;
  logic       go;
  logic       core_start;
  logic       core_abort;
  logic       core_done;
  logic [9:0] core_result;
  logic [2:0] cur_chan;
  logic [1:0] next_idx;
  logic [2:0] start_chan;
  logic [1:0] res_idx;
  logic       res_hi_rd;
  logic       pass_end;
  logic [9:0] sample;
  logic [9:0] ain [8];

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  // Standby clears everything, same as a reset
  assign clr_n     = resetn && !standby;
  assign csr_wr    = cpu_wr && (cpu_addr == `ADCSC_ADDR_CSR);
  assign trg_wr    = cpu_wr && (cpu_addr == `ADCSC_ADDR_TRG);
  assign res_hi_rd = cpu_rd && (cpu_addr <= `ADCSC_ADDR_RES_LAST) && !cpu_addr[0];
  assign res_idx   = cpu_addr[2:1];

  // Falling edge only while enabled
  assign trig_fall = ext_trigger_enable_q && trg_pin_q && !ext_trigger_pin;

  assign ain[0] = analog_input_0;
  assign ain[1] = analog_input_1;
  assign ain[2] = analog_input_2;
  assign ain[3] = analog_input_3;
  assign ain[4] = analog_input_4;
  assign ain[5] = analog_input_5;
  assign ain[6] = analog_input_6;
  assign ain[7] = analog_input_7;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing

  // Scan: group from the top bit, then a running offset from its first channel
  assign cur_chan = scan_mode_q ? {channel_field_q[2], scan_idx_q}
                                : channel_field_q;
  // A back-to-back scan start must sample the next channel, not the finished one
  assign next_idx   = pass_end ? 2'h0 : scan_idx_q + 2'h1;
  assign start_chan = (scan_mode_q && core_done) ? {channel_field_q[2], next_idx}
                                                 : cur_chan;
  assign sample     = ain[start_chan];

  // Scan pass ends when the offset reaches the count in the low bits
  assign pass_end = !scan_mode_q || (scan_idx_q == channel_field_q[1:0]);

  assign go = conversion_start_bit_q;

  // Clearing the start bit stops the core mid-conversion
  assign core_abort = (state_q == adcsc_pkg::ADCSC_BUSY) && !go;

  always_comb begin
    core_start = 1'b0;
    case (state_q)
      adcsc_pkg::ADCSC_IDLE: begin
        core_start = go;
      end
      adcsc_pkg::ADCSC_BUSY: begin
        // Next scan channel, or restart of the group after a pass
        core_start = core_done && go && scan_mode_q;
      end
      default: begin
        core_start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      state_q <= adcsc_pkg::ADCSC_IDLE;
    end else begin
      case (state_q)
        adcsc_pkg::ADCSC_IDLE: begin
          if (go) begin
            state_q <= adcsc_pkg::ADCSC_BUSY;
          end
        end
        adcsc_pkg::ADCSC_BUSY: begin
          if (!go || (core_done && !scan_mode_q)) begin
            state_q <= adcsc_pkg::ADCSC_IDLE;
          end
        end
        default: begin
          state_q <= adcsc_pkg::ADCSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      scan_idx_q <= 2'h0;
    end else if (state_q == adcsc_pkg::ADCSC_IDLE || !go) begin
      scan_idx_q <= 2'h0;
    end else if (core_done) begin
      scan_idx_q <= next_idx;
    end
  end

  adcsc_core u_core (
    .clk    (clk),
    .resetn (clr_n),
    .start  (core_start),
    .abort  (core_abort),
    .fast   (conv_time_select_q),
    .sample (sample),
    .done   (core_done),
    .result (core_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Result registers

  generate
    for (genvar i = 0; i < 4; i++) begin : g_res
      always_ff @(posedge clk) begin
        if (!clr_n) begin
          result_q[i] <= `ADCSC_RES_RESET;
        end else if (core_done && go && cur_chan[1:0] == 2'(i)) begin
          result_q[i] <= core_result;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Control and status

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      conversion_start_bit_q <= 1'b0;
    end else if (trig_fall) begin
      conversion_start_bit_q <= 1'b1;
    end else if (csr_wr) begin
      conversion_start_bit_q <= cpu_wdata[`ADCSC_CSR_START];
    end else if (core_done && !scan_mode_q && state_q == adcsc_pkg::ADCSC_BUSY) begin
      conversion_start_bit_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      end_interrupt_enable_q <= 1'b0;
      scan_mode_q            <= 1'b0;
      conv_time_select_q     <= 1'b0;
      channel_field_q        <= 3'h0;
    end else if (csr_wr) begin
      end_interrupt_enable_q <= cpu_wdata[`ADCSC_CSR_IE];
      scan_mode_q            <= cpu_wdata[`ADCSC_CSR_SCAN];
      // Changing it with the start bit set is a software fault
      conv_time_select_q     <= cpu_wdata[`ADCSC_CSR_CKS];
      channel_field_q        <= cpu_wdata[2:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!clr_n) begin
      conversion_end_flag_q <= 1'b0;
    end else if (core_done && go && pass_end) begin
      conversion_end_flag_q <= 1'b1;
    end else if (csr_wr && !cpu_wdata[`ADCSC_CSR_FLAG] && flag_read_one_q) begin
      conversion_end_flag_q <= 1'b0;
    end
  end

  // Remembers a read of the flag as 1 until the next control write
  always_ff @(posedge clk) begin
    if (!clr_n) begin
      flag_read_one_q <= 1'b0;
    end else if (csr_wr) begin
      flag_read_one_q <= 1'b0;
    end else if (cpu_rd && cpu_addr == `ADCSC_ADDR_CSR && conversion_end_flag_q) begin
      flag_read_one_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      ext_trigger_enable_q <= 1'b0;
      trg_rsvd0_q          <= 1'b0;
    end else if (trg_wr) begin
      ext_trigger_enable_q <= cpu_wdata[`ADCSC_TRG_EN];
      trg_rsvd0_q          <= cpu_wdata[0];
    end
  end

  // Idles high, so a pin low out of reset reads as an edge in the first cycle; the cleared enable masks it
  always_ff @(posedge clk) begin
    if (!clr_n) begin
      trg_pin_q <= 1'b1;
    end else begin
      trg_pin_q <= ext_trigger_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      conversion_end_irq <= 1'b0;
    end else begin
      conversion_end_irq <= conversion_end_flag_q && end_interrupt_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  // Lower byte is captured at the upper-byte read so a byte pair stays coherent
  always_ff @(posedge clk) begin
    if (!clr_n) begin
      temp_q <= 8'h00;
    end else if (res_hi_rd && !cpu_word) begin
      temp_q <= {result_q[res_idx][1:0], `ADCSC_RES_PAD};
    end
  end

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      cpu_rdata <= 16'h0000;
    end else if (cpu_rd) begin
      if (cpu_addr <= `ADCSC_ADDR_RES_LAST && cpu_word) begin
        cpu_rdata <= {result_q[res_idx], `ADCSC_RES_PAD};
      end else if (cpu_addr <= `ADCSC_ADDR_RES_LAST && !cpu_addr[0]) begin
        cpu_rdata <= {8'h00, result_q[res_idx][9:2]};
      end else if (cpu_addr <= `ADCSC_ADDR_RES_LAST) begin
        cpu_rdata <= {8'h00, temp_q};
      end else if (cpu_addr == `ADCSC_ADDR_CSR) begin
        cpu_rdata <= {8'h00, conversion_end_flag_q, end_interrupt_enable_q,
                      conversion_start_bit_q, scan_mode_q, conv_time_select_q,
                      channel_field_q};
      end else if (cpu_addr == `ADCSC_ADDR_TRG) begin
        cpu_rdata <= {8'h00, ext_trigger_enable_q, `ADCSC_TRG_RSVD, trg_rsvd0_q};
      end else begin
        cpu_rdata <= 16'h0000;
      end
    end
  end

endmodule
`default_nettype wire

// >>> adcsc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcsc_analog_model (
  // Clock and trigger request
  input  wire logic clk,
  input  wire logic trig_req,
  // Levels and trigger pin
  output logic [9:0] ain [8],
  output logic       ext_trigger_pin
);
  ////////////////////////////////////////
  // A distinct level on every input, so a misrouted result shows
  always_comb begin
    for (int k = 0; k < 8; k++) ain[k] = {k[2:0], 7'h4b} ^ 10'(k);
  end
  // Pin idles high; a request gives one low cycle
  initial ext_trigger_pin = 1'b1;
  always @(posedge clk) ext_trigger_pin <= !trig_req;
endmodule
`default_nettype wire

// >>> adcsc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcsc_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        standby,
  // CPU port and interrupt
  input wire logic [3:0]  cpu_addr,
  input wire logic        cpu_rd,
  input wire logic        cpu_word,
  input wire logic [15:0] cpu_rdata,
  input wire logic        conversion_end_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || standby);
  ////////////////////////////////////////
  property p_word_pad;
    $past(cpu_rd && cpu_word && cpu_addr < 4'h8) |-> cpu_rdata[5:0] == 6'h00;
  endproperty
  a_word_pad: assert property (p_word_pad) else $error("word pad not zero");
  property p_low_byte;
    $past(cpu_rd && !cpu_word && cpu_addr < 4'h8 && cpu_addr[0])
      |-> cpu_rdata[15:8] == 8'h00 && cpu_rdata[5:0] == 6'h00;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte bad");
  property p_high_byte;
    $past(cpu_rd && !cpu_word && cpu_addr < 4'h8 && !cpu_addr[0]) |-> cpu_rdata[15:8] == 8'h00;
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte bad");
  property p_hold;
    !cpu_rd |=> $stable(cpu_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_irq_match;
    $past(cpu_rd && cpu_addr == 4'h8) |-> conversion_end_irq == (cpu_rdata[7] && cpu_rdata[6]);
  endproperty
  a_irq_match: assert property (p_irq_match) else $error("irq disagrees with flags");
  property p_unmapped;
    $past(cpu_rd && cpu_addr > 4'h9) |-> cpu_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_trg_rsvd;
    $past(cpu_rd && cpu_addr == 4'h9) |-> cpu_rdata[15:8] == 8'h00 && cpu_rdata[6:1] == 6'h3f;
  endproperty
  a_trg_rsvd: assert property (p_trg_rsvd) else $error("trigger reg bad");
  property p_standby;
    disable iff (!resetn) standby |=> !conversion_end_irq && cpu_rdata == 16'h0000;
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not clear");
endmodule
bind adcsc_top adcsc_assertions u_chk (.clk(clk), .resetn(resetn), .standby(standby),
  .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_word(cpu_word), .cpu_rdata(cpu_rdata),
  .conversion_end_irq(conversion_end_irq));
`default_nettype wire

// >>> adc_sequencer_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_tb_top;
  logic clk = 1'b0, resetn = 1'b0, standby = 1'b0, cpu_rd = 1'b0, cpu_wr = 1'b0;
  logic cpu_word = 1'b0, trig_req = 1'b0, irq, ext_trigger_pin;
  logic [3:0] cpu_addr = 4'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [15:0] cpu_rdata, r;
  logic [9:0] ain [8];
  int bad_count = 0, comparisons = 0, n;
  always #12.5 clk = !clk;
  adcsc_analog_model u_far (.clk(clk), .trig_req(trig_req), .ain(ain),
    .ext_trigger_pin(ext_trigger_pin));
  adcsc_top u_dut (.clk(clk), .resetn(resetn), .standby(standby), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_word(cpu_word), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .analog_input_0(ain[0]), .analog_input_1(ain[1]),
    .analog_input_2(ain[2]), .analog_input_3(ain[3]), .analog_input_4(ain[4]),
    .analog_input_5(ain[5]), .analog_input_6(ain[6]), .analog_input_7(ain[7]),
    .ext_trigger_pin(ext_trigger_pin), .conversion_end_irq(irq));
  ////////////////////////////////////////
  function automatic logic [15:0] res(input int k);
    return {{k[2:0], 7'h4b} ^ 10'(k), 6'h00};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic w);
    @(posedge clk);
    cpu_addr <= a;
    cpu_word <= w;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    @(posedge clk);
    #1 r = cpu_rdata;
  endtask
  task automatic wait_flag();
    n = 0;
    do begin
      rd(4'h8, 1'b0);
      n++;
    end while (r[7] !== 1'b1 && n < 400);
    if (r[7] !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////
  task automatic reset_values();
    wr(4'h0, 8'hff);
    for (int k = 0; k < 16; k++) begin
      rd(4'(k), 1'b0);
      chk(r, (k == 9) ? 16'h007e : 16'h0000);
    end
  endtask
  task automatic single_all();
    for (int k = 0; k < 8; k++) begin
      wr(4'h8, 8'h28 | 8'(k));
      wait_flag();
      chk({15'h0, r[5]}, 16'h0);
      rd(4'(2 * (k % 4)), 1'b1);
      chk(r, res(k));
      wr(4'h8, 8'h08);
    end
  endtask
  task automatic byte_order();
    rd(4'h6, 1'b0);
    chk(r, {8'h00, 8'(res(7) >> 8)});
    rd(4'h0, 1'b0);
    rd(4'h2, 1'b1);
    rd(4'h7, 1'b0);
    chk(r, {8'h00, 8'(res(4))});
  endtask
  task automatic flag_irq();
    wr(4'h8, 8'h68);
    wait_flag();
    chk({15'h0, irq}, 16'h1);
    wr(4'h8, 8'h88);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0);
    wr(4'h8, 8'hc8);
    wr(4'h8, 8'h48);
    rd(4'h8, 1'b0);
    chk(r, 16'h00c8);
    wr(4'h8, 8'h48);
    rd(4'h8, 1'b0);
    chk(r, 16'h0048);
    chk({15'h0, irq}, 16'h0);
  endtask
  task automatic conv_time();
    for (int c = 0; c < 2; c++) begin
      wr(4'h8, c ? 8'h68 : 8'h60);
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
        @(posedge clk);
        #1 n++;
      end
      chk(16'(n >= (c ? 70 : 134) && n <= (c ? 76 : 140)), 16'h1);
      if (n >= 300) finish_test();
      rd(4'h8, 1'b0);
      wr(4'h8, 8'h48);
    end
  endtask
  task automatic scan_run();
    wr(4'h8, 8'h39);
    wait_flag();
    chk({15'h0, r[5]}, 16'h1);
    wr(4'h8, 8'h39);
    wait_flag();
    for (int k = 0; k < 3; k++) begin
      rd(4'(2 * k), 1'b1);
      chk(r, res(k == 2 ? 6 : k));
    end
    wr(4'h8, 8'h08);
    rd(4'h8, 1'b0);
    chk({15'h0, r[5]}, 16'h0);
    wr(4'h8, 8'h3d);
    wait_flag();
    for (int k = 0; k < 2; k++) begin
      rd(4'(2 * k), 1'b1);
      chk(r, res(k + 4));
    end
    wr(4'h8, 8'h08);
    wr(4'h8, 8'h3b);
    repeat (20) @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rd(4'h8, 1'b0);
    chk(r, 16'h0000);
  endtask
  task automatic trigger_start();
    wr(4'h9, 8'h80);
    wr(4'h8, 8'h0a);
    @(posedge clk);
    trig_req <= 1'b1;
    @(posedge clk);
    trig_req <= 1'b0;
    wait_flag();
    rd(4'h4, 1'b1);
    chk(r, res(2));
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    reset_values();
    single_all();
    byte_order();
    flag_irq();
    conv_time();
    scan_run();
    trigger_start();
    finish_test();
  end
endmodule
`default_nettype wire
